// ===== hw/i2cs_fifo.sv
`timescale 1ns/100ps
module i2cs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  i2cs_stream_if.snk  inS,
  i2cs_stream_if.src  outS
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   DEPTH_CNT = PW'(DEPTH) == '0 ? {1'b1, {PW{1'b0}}} : {1'b0, PW'(DEPTH)};
  localparam logic [PW-1:0] LAST_PTR  = PW'(DEPTH - 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("i2cs_fifo needs a depth of at least two");
  end
  if (W < 1) begin : g_bad_width
    $error("i2cs_fifo needs a width of at least one");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0]   count_q;
  logic [PW:0]   count_d;
  logic          notFull_q;
  logic          empty_q;
  logic          push;
  logic          pop;

  // ready is kept as its own flop so the top's ready output leaves a register
  assign push       = inS.valid && notFull_q;
  assign pop        = outS.ready && !empty_q;
  assign inS.ready  = notFull_q;
  assign outS.valid = !empty_q;
  assign outS.data  = mem[rdPtr_q];
  assign count_d    = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inS.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_d;
      notFull_q <= (count_d != DEPTH_CNT);
      empty_q <= (count_d == '0);
    end
  end
endmodule

// ===== hw/i2cs_line_watch.sv
`timescale 1ns/100ps
module i2cs_line_watch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startDet,
  output logic      stopDet
);
  logic sclPrev_q;
  logic sdaPrev_q;

  // idle bus level is high, so reset to high avoids a false edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  assign sclRise  = sclIn && !sclPrev_q;
  assign sclFall  = !sclIn && sclPrev_q;
  assign startDet = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
  assign stopDet  = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;
endmodule

// ===== hw/i2cs_pkg.sv
package i2cs_pkg;

  localparam int          DATA_W         = 8;
  localparam int          TX_FIFO_DEPTH  = 8;

  // port mode selections
  localparam logic [3:0]  MODE_SLV7      = 4'h6;
  localparam logic [3:0]  MODE_SLV10     = 4'h7;
  localparam logic [3:0]  MODE_MASTER    = 4'h8;
  localparam logic [3:0]  MODE_FW7_INT   = 4'hE;
  localparam logic [3:0]  MODE_FW10_INT  = 4'hF;

  localparam logic [4:0]  TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT    = 4'h7;
  localparam logic [3:0]  BIT_CNT_RESET  = 4'h0;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [7:0]  BUF_RESET      = 8'h00;
  localparam logic [7:0]  IDLE_TX_BYTE   = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } i2cs_state_t;

endpackage

// ===== hw/i2cs_stream_if.sv
`timescale 1ns/100ps
interface i2cs_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== hw/i2cs_top.sv
// Operation
// - four mode bits select 7-bit slave, 10-bit slave, master or firmware modes
// - port enable turns the port on and takes over clock and data pins
// - status shows start, stop, address or data, pending 10-bit update, direction
// - after a start, eight bits shift in, each sampled on a clock rise
// - at the eighth clock fall, shift bits seven to one meet the address
// - clean match loads buffer, sets full at eighth fall, acks, interrupts ninth
// - matched address and following data bytes are acked and buffered automatically
// - no acknowledge when buffer-full or overflow was already set
// - buffer-full set: buffer kept, byte dropped, interrupt and overflow set
// - reading the buffer clears buffer-full; overflow stays until software clears it
// - overflow set, buffer-full clear: buffer loads but no acknowledge
// - interrupt flag set per received byte, held until software clears it
// - write-direction match clears direction bit and buffers the address byte
// - 10-bit first byte is prefix 11110, A9, A8, write bit
// - each 10-bit write address byte sets update flag, full, interrupt, holds clock low
// - after repeated start in 10-bit mode only a high byte with the read bit set must match
// - as transmitter the port drives its own bits over the data pin
`timescale 1ns/100ps
module i2cs_top
  import i2cs_pkg::*;
#(
  parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              portEnable,
  input  wire logic [3:0]        modeSel,
  input  wire logic [DATA_W-1:0] addrWrData,
  input  wire logic              addrWrStrobe,
  input  wire logic              rxBufRead,
  input  wire logic              overflowClear,
  input  wire logic              intFlagClear,
  input  wire logic [DATA_W-1:0] txData,
  input  wire logic              txValid,
  output logic                   txReady,
  input  wire logic              sclIn,
  output logic                   sclOut,
  output logic                   sclOeN,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOeN,
  output logic [DATA_W-1:0]      rxBufData,
  output logic [DATA_W-1:0]      slaveAddr,
  output logic                   bufferFull,
  output logic                   receiveOverflow,
  output logic                   portIntFlag,
  output logic                   startSeen,
  output logic                   stopSeen,
  output logic                   dataNotAddr,
  output logic                   updateAddr,
  output logic                   readNotWrite
);
  if (TX_DEPTH < 2) begin : g_bad_depth
    $error("i2cs_top needs a transmit depth of at least two");
  end

  i2cs_stream_if #(.W(DATA_W)) txIn ();
  i2cs_stream_if #(.W(DATA_W)) txOut ();

  i2cs_fifo #(
    .W     (DATA_W),
    .DEPTH (TX_DEPTH)
  ) u_txFifo (
    .clk   (clk),
    .rst_n (rst_n),
    .inS   (txIn.snk),
    .outS  (txOut.src)
  );

  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  i2cs_line_watch u_lineWatch (
    .clk      (clk),
    .rst_n    (rst_n),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .startDet (startDet),
    .stopDet  (stopDet)
  );

  i2cs_state_t       state_q,       state_d;
  logic [7:0]        shift_q,       shift_d;
  logic [3:0]        bitCnt_q,      bitCnt_d;
  logic              addrByte_q,    addrByte_d;
  logic              tenLow_q,      tenLow_d;
  logic              highMatched_q, highMatched_d;
  logic              ackGive_q,     ackGive_d;
  logic              isRead_q,      isRead_d;
  logic              masterAck_q,   masterAck_d;
  logic [7:0]        txShift_q,     txShift_d;
  logic              sdaOeN_q,      sdaOeN_d;
  logic              sclOeN_q,      sclOeN_d;
  logic [7:0]        rxBuf_q;
  logic [7:0]        addr_q;
  logic              bf_q;
  logic              ov_q;
  logic              if_q;
  logic              ua_q;
  logic              start_q;
  logic              stop_q;
  logic              dan_q;
  logic              rw_q;

  // mode decode; master mode leaves the slave idle, firmware modes run it
  logic slave7;
  logic slave10;
  logic slaveOn;
  assign slave7  = (modeSel == MODE_SLV7) || (modeSel == MODE_FW7_INT);
  assign slave10 = (modeSel == MODE_SLV10) || (modeSel == MODE_FW10_INT);
  assign slaveOn = portEnable && (slave7 || slave10);

  // address compare at the eighth falling edge
  logic byteDone;
  logic match7;
  logic matchHi;
  logic matchLo;
  logic addrHit;
  logic acceptByte;
  logic dropAddr;
  assign byteDone = (state_q == ST_RX) && sclFall && (bitCnt_q == BITS_PER_BYTE);
  assign match7   = (shift_q[7:1] == addr_q[7:1]);
  assign matchHi  = match7 && (shift_q[7:3] == TEN_BIT_PREFIX)
                    && (!shift_q[0] || highMatched_q);
  assign matchLo  = (shift_q == addr_q);
  assign addrHit  = slave7 ? match7 : (tenLow_q ? matchLo : matchHi);
  assign acceptByte = byteDone && (!addrByte_q || addrHit);
  assign dropAddr   = byteDone && addrByte_q && !addrHit;

  logic loadBuf;
  logic setOv;
  logic ackNow;
  logic setUa;
  logic readGo;
  logic ninthFall;
  logic isAddrByte;
  assign isAddrByte = acceptByte && addrByte_q;
  assign loadBuf    = acceptByte && !bf_q;
  assign setOv      = acceptByte && bf_q;
  assign ackNow     = acceptByte && !bf_q && !ov_q;
  assign setUa      = isAddrByte && slave10 && (tenLow_q || !shift_q[0]);
  assign readGo     = isAddrByte && !tenLow_q && shift_q[0];
  assign ninthFall  = (state_q == ST_ACK) && sclFall;

  // transmit byte is taken from the queue; an empty queue sends all ones
  logic txTake;
  logic [7:0] txNext;
  assign txTake = (ninthFall && isRead_q && ackGive_q)
                  || ((state_q == ST_TXACK) && sclFall && masterAck_q);
  assign txNext = txOut.valid ? txOut.data : IDLE_TX_BYTE;
  assign txOut.ready = txTake;
  assign txIn.data   = txData;
  assign txIn.valid  = txValid;

  always_comb begin
    state_d       = state_q;
    shift_d       = shift_q;
    bitCnt_d      = bitCnt_q;
    addrByte_d    = addrByte_q;
    tenLow_d      = tenLow_q;
    highMatched_d = highMatched_q;
    ackGive_d     = ackGive_q;
    isRead_d      = isRead_q;
    masterAck_d   = masterAck_q;
    txShift_d     = txShift_q;
    sdaOeN_d      = sdaOeN_q;
    sclOeN_d      = sclOeN_q;
    if (addrWrStrobe) begin
      sclOeN_d = 1'b1;
    end
    if (!slaveOn) begin
      state_d       = ST_IDLE;
      sdaOeN_d      = 1'b1;
      sclOeN_d      = 1'b1;
      highMatched_d = 1'b0;
    end else if (startDet) begin
      // a repeated start keeps the 10-bit match
      state_d    = ST_RX;
      bitCnt_d   = BIT_CNT_RESET;
      addrByte_d = 1'b1;
      tenLow_d   = 1'b0;
      sdaOeN_d   = 1'b1;
    end else if (stopDet) begin
      state_d       = ST_IDLE;
      sdaOeN_d      = 1'b1;
      highMatched_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (sclRise && (bitCnt_q != BITS_PER_BYTE)) begin
            shift_d  = {shift_q[6:0], sdaIn};
            bitCnt_d = bitCnt_q + 1'b1;
          end
          if (dropAddr) begin
            state_d       = ST_IDLE;
            highMatched_d = 1'b0;
          end else if (acceptByte) begin
            state_d   = ST_ACK;
            ackGive_d = ackNow;
            sdaOeN_d  = !ackNow;
            if (isAddrByte) begin
              isRead_d = readGo;
              if (slave10 && !tenLow_q && !shift_q[0]) begin
                tenLow_d = 1'b1;
              end else begin
                addrByte_d = 1'b0;
                tenLow_d   = 1'b0;
              end
              if (slave10 && tenLow_q) begin
                highMatched_d = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCnt_d = BIT_CNT_RESET;
            sdaOeN_d = 1'b1;
            if (ua_q && !addrWrStrobe) begin
              sclOeN_d = 1'b0;
            end
            if (!ackGive_q) begin
              state_d = ST_IDLE;
            end else if (isRead_q) begin
              state_d   = ST_TX;
              txShift_d = txNext;
              sdaOeN_d  = txNext[7];
            end else begin
              state_d = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_q == LAST_TX_BIT) begin
              state_d  = ST_TXACK;
              sdaOeN_d = 1'b1;
            end else begin
              bitCnt_d  = bitCnt_q + 1'b1;
              txShift_d = {txShift_q[6:0], 1'b1};
              sdaOeN_d  = txShift_q[6];
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            masterAck_d = !sdaIn;
          end
          if (sclFall) begin
            bitCnt_d = BIT_CNT_RESET;
            if (masterAck_q) begin
              state_d   = ST_TX;
              txShift_d = txNext;
              sdaOeN_d  = txNext[7];
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      shift_q       <= BUF_RESET;
      bitCnt_q      <= BIT_CNT_RESET;
      addrByte_q    <= 1'b1;
      tenLow_q      <= 1'b0;
      highMatched_q <= 1'b0;
      ackGive_q     <= 1'b0;
      isRead_q      <= 1'b0;
      masterAck_q   <= 1'b0;
      txShift_q     <= IDLE_TX_BYTE;
      sdaOeN_q      <= 1'b1;
      sclOeN_q      <= 1'b1;
    end else begin
      state_q       <= state_d;
      shift_q       <= shift_d;
      bitCnt_q      <= bitCnt_d;
      addrByte_q    <= addrByte_d;
      tenLow_q      <= tenLow_d;
      highMatched_q <= highMatched_d;
      ackGive_q     <= ackGive_d;
      isRead_q      <= isRead_d;
      masterAck_q   <= masterAck_d;
      txShift_q     <= txShift_d;
      sdaOeN_q      <= sdaOeN_d;
      sclOeN_q      <= sclOeN_d;
    end
  end

  // software-visible flags; hardware set wins over a same-cycle clear
  logic bf_d;
  logic ov_d;
  logic if_d;
  logic ua_d;
  assign bf_d = loadBuf || (bf_q && !rxBufRead);
  assign ov_d = setOv || (ov_q && !overflowClear);
  assign if_d = ninthFall || (if_q && !intFlagClear);
  assign ua_d = setUa || (ua_q && !addrWrStrobe);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q <= BUF_RESET;
      addr_q  <= ADDR_RESET;
      bf_q    <= 1'b0;
      ov_q    <= 1'b0;
      if_q    <= 1'b0;
      ua_q    <= 1'b0;
    end else begin
      if (loadBuf) begin
        rxBuf_q <= shift_q;
      end
      if (addrWrStrobe) begin
        addr_q <= addrWrData;
      end
      bf_q <= bf_d;
      ov_q <= ov_d;
      if_q <= if_d;
      ua_q <= ua_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      dan_q   <= 1'b0;
      rw_q    <= 1'b0;
    end else begin
      if (slaveOn && startDet) begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end else if (slaveOn && stopDet) begin
        start_q <= 1'b0;
        stop_q  <= 1'b1;
      end
      if (acceptByte) begin
        dan_q <= !addrByte_q;
      end
      if (isAddrByte && !tenLow_q) begin
        rw_q <= shift_q[0];
      end
    end
  end

  assign sclOut          = 1'b0;
  assign sdaOut          = 1'b0;
  assign sclOeN          = sclOeN_q;
  assign sdaOeN          = sdaOeN_q;
  assign txReady         = txIn.ready;
  assign rxBufData       = rxBuf_q;
  assign slaveAddr       = addr_q;
  assign bufferFull      = bf_q;
  assign receiveOverflow = ov_q;
  assign portIntFlag     = if_q;
  assign startSeen       = start_q;
  assign stopSeen        = stop_q;
  assign dataNotAddr     = dan_q;
  assign updateAddr      = ua_q;
  assign readNotWrite    = rw_q;
endmodule

// ===== verification/i2cs_bus_master.sv
`timescale 1ns/100ps
module i2cs_bus_master (
  input  wire logic clk,
  input  wire logic sclOeN,
  input  wire logic sdaOeN,
  input  wire logic sclOut,
  input  wire logic sdaOut,
  output logic      sclIn,
  output logic      sdaIn
);
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;

  // pulled-up open-drain lines: a released line reads high
  assign sclIn = sclDrv & (sclOeN | sclOut);
  assign sdaIn = sdaDrv & (sdaOeN | sdaOut);

  task automatic qtr();
    repeat (4) @(negedge clk);
  endtask

  task automatic clk_bit(input logic b, output logic s);
    int n;
    n = 0;
    sdaDrv = b;
    qtr();
    sclDrv = 1'b1;
    // the slave may stretch the low phase; the bench frees it first
    while (!sclIn && n < 2000) begin
      @(negedge clk);
      n++;
    end
    qtr();
    s = sdaIn;
    qtr();
    sclDrv = 1'b0;
    qtr();
  endtask

  task automatic start();
    sdaDrv = 1'b1;
    qtr();
    sclDrv = 1'b1;
    qtr();
    sdaDrv = 1'b0;
    qtr();
    sclDrv = 1'b0;
    qtr();
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    qtr();
    sclDrv = 1'b1;
    qtr();
    sdaDrv = 1'b1;
    qtr();
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic rd_byte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!ackIt, s);
  endtask
endmodule

// ===== verification/i2cs_top_assertions.sv
`timescale 1ns/100ps
module i2cs_top_assertions
  import i2cs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       portEnable,
  input wire logic [3:0] modeSel,
  input wire logic       addrWrStrobe,
  input wire logic       rxBufRead,
  input wire logic       overflowClear,
  input wire logic       intFlagClear,
  input wire logic       sclIn,
  input wire logic       sclOeN,
  input wire logic       sdaIn,
  input wire logic       sdaOeN,
  input wire logic       bufferFull,
  input wire logic       receiveOverflow,
  input wire logic       portIntFlag,
  input wire logic       startSeen,
  input wire logic       stopSeen,
  input wire logic       updateAddr,
  input wire logic       readNotWrite
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ack_gate_a: assert property ($fell(sdaOeN) && !$past(readNotWrite) |-> !$past(bufferFull, 2) &&
    !$past(receiveOverflow, 2)) else $error("ack given while full or overflow");
  ack_hold_a: assert property ($fell(sdaOeN) && !$past(readNotWrite) |-> !sdaOeN[*3] ##[1:40] sdaOeN)
    else $error("ack not held then released");
  sda_scl_low_a: assert property ($changed(sdaOeN) |-> !sclIn)
    else $error("data line moved while clock high");
  full_int_a: assert property ($rose(bufferFull) |-> ##[1:40] portIntFlag)
    else $error("interrupt flag missing after byte");
  int_sticky_a: assert property (portIntFlag && !intFlagClear |=> portIntFlag)
    else $error("interrupt flag dropped without clear");
  ovf_sticky_a: assert property (receiveOverflow && !overflowClear |=> receiveOverflow)
    else $error("overflow dropped without clear");
  read_clr_a: assert property (rxBufRead && sclIn == $past(sclIn) && sclIn == $past(sclIn, 3)
    |=> !bufferFull) else $error("buffer read did not clear full");
  stretch_cause_a: assert property ($fell(sclOeN) |-> updateAddr)
    else $error("clock held without address update");
  stretch_free_a: assert property (addrWrStrobe |-> ##[1:2] (sclOeN && !updateAddr))
    else $error("address write did not release clock");
  stop_det_a: assert property (portEnable && modeSel == MODE_SLV7 && sclIn && $past(sclIn) && $rose(sdaIn)
    |-> ##[1:3] (stopSeen && !startSeen)) else $error("stop not reported");
  start_det_a: assert property (portEnable && modeSel == MODE_SLV7 && sclIn && $past(sclIn) && $fell(sdaIn)
    |-> ##[1:3] (startSeen && !stopSeen)) else $error("start not reported");
endmodule

bind i2cs_top i2cs_top_assertions chk (.clk, .rst_n, .portEnable, .modeSel, .addrWrStrobe, .rxBufRead,
  .overflowClear, .intFlagClear, .sclIn, .sclOeN, .sdaIn, .sdaOeN, .bufferFull, .receiveOverflow,
  .portIntFlag, .startSeen, .stopSeen, .updateAddr, .readNotWrite);

// ===== verification/test_i2c_slave_receive_addressing.sv
`timescale 1ns/100ps
module test_i2c_slave_receive_addressing
  import i2cs_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              portEnable = 1'b1;
  logic [3:0]        modeSel = MODE_SLV7;
  logic [DATA_W-1:0] addrWrData = 8'h00;
  logic [DATA_W-1:0] txData = 8'h00;
  logic              addrWrStrobe = 1'b0, rxBufRead = 1'b0, overflowClear = 1'b0;
  logic              intFlagClear = 1'b0, txValid = 1'b0;
  logic              txReady, sclIn, sclOeN, sdaIn, sdaOeN, ack, sclOut, sdaOut;
  logic [DATA_W-1:0] rxBufData, slaveAddr;
  logic              bufferFull, receiveOverflow, portIntFlag, startSeen, stopSeen;
  logic              dataNotAddr, updateAddr, readNotWrite;
  int                error_cnt = 0;
  int                num_checks = 0;

  i2cs_top DUT (.clk, .rst_n, .portEnable, .modeSel, .addrWrData, .addrWrStrobe, .rxBufRead, .overflowClear,
    .intFlagClear, .txData, .txValid, .txReady, .sclIn, .sclOut, .sclOeN, .sdaIn, .sdaOut, .sdaOeN,
    .rxBufData, .slaveAddr, .bufferFull, .receiveOverflow, .portIntFlag, .startSeen, .stopSeen,
    .dataNotAddr, .updateAddr, .readNotWrite);
  i2cs_bus_master bus (.clk, .sclOeN, .sdaOeN, .sclOut, .sdaOut, .sclIn, .sdaIn);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask

  task automatic set_addr(input logic [7:0] a);
    addrWrData = a;
    pulse(addrWrStrobe);
  endtask

  task automatic clr_sw();
    pulse(rxBufRead);
    pulse(intFlagClear);
  endtask

  task automatic t_modes();
    logic [3:0] md [4] = '{MODE_SLV7, MODE_FW7_INT, MODE_MASTER, MODE_SLV10};
    set_addr(8'h66);
    chk("address reg", slaveAddr, 8'h66);
    for (int i = 0; i < 4; i++) begin
      modeSel = md[i];
      bus.start();
      bus.wr_byte(8'h66, ack);
      bus.stop();
      chk("mode ack", {7'h00, ack}, {7'h00, i < 2});
      clr_sw();
    end
    modeSel = MODE_SLV7;
    portEnable = 1'b0;
    bus.start();
    bus.wr_byte(8'h66, ack);
    bus.stop();
    portEnable = 1'b1;
    chk("disabled ack", {7'h00, ack}, 8'h00);
  endtask

  task automatic t_overflow();
    bus.start();
    bus.wr_byte(8'h66, ack);
    chk("addr ack", {7'h00, ack}, 8'h01);
    chk("addr in buffer", rxBufData, 8'h66);
    chk("direction", {7'h00, readNotWrite}, 8'h00);
    chk("full", {7'h00, bufferFull}, 8'h01);
    chk("interrupt", {7'h00, portIntFlag}, 8'h01);
    chk("addr kind", {7'h00, dataNotAddr}, 8'h00);
    chk("start seen", {7'h00, startSeen}, 8'h01);
    pulse(intFlagClear);
    bus.wr_byte(8'h5A, ack);
    bus.stop();
    chk("full ack", {7'h00, ack}, 8'h00);
    chk("kept buffer", rxBufData, 8'h66);
    chk("overflow", {7'h00, receiveOverflow}, 8'h01);
    chk("interrupt", {7'h00, portIntFlag}, 8'h01);
    chk("stop seen", {7'h00, stopSeen}, 8'h01);
    clr_sw();
    chk("full cleared", {7'h00, bufferFull}, 8'h00);
    chk("overflow kept", {7'h00, receiveOverflow}, 8'h01);
    set_addr(8'h3E);
    bus.start();
    bus.wr_byte(8'h3E, ack);
    bus.stop();
    chk("overflow ack", {7'h00, ack}, 8'h00);
    chk("overflow load", rxBufData, 8'h3E);
    pulse(overflowClear);
    clr_sw();
    chk("overflow clear", {7'h00, receiveOverflow}, 8'h00);
    bus.start();
    bus.wr_byte(8'h3E, ack);
    // clear both so the data byte must set the interrupt on its own
    clr_sw();
    bus.wr_byte(8'hC3, ack);
    chk("data ack", {7'h00, ack}, 8'h01);
    chk("data buffer", rxBufData, 8'hC3);
    chk("data kind", {7'h00, dataNotAddr}, 8'h01);
    chk("data interrupt", {7'h00, portIntFlag}, 8'h01);
    bus.stop();
    clr_sw();
    bus.start();
    bus.wr_byte(8'h3C, ack);
    bus.stop();
    chk("miss ack", {7'h00, ack}, 8'h00);
    chk("miss full", {7'h00, bufferFull}, 8'h00);
  endtask

  task automatic t_ten();
    logic [7:0] d;
    int         n;
    modeSel = MODE_FW10_INT;
    set_addr(8'hF2);
    // fill the transmit queue until it refuses
    for (n = 0; n < 12 && txReady; n++) begin
      txData = 8'(8'hC0 + n);
      txValid = 1'b1;
      @(negedge clk);
    end
    txValid = 1'b0;
    chk("queue depth", 8'(n), 8'(TX_FIFO_DEPTH));
    bus.start();
    bus.wr_byte(8'hF2, ack);
    chk("high ack", {7'h00, ack}, 8'h01);
    chk("update", {7'h00, updateAddr}, 8'h01);
    chk("stretch", {7'h00, sclOeN}, 8'h00);
    set_addr(8'h34);
    chk("released", {7'h00, sclOeN}, 8'h01);
    chk("update clr", {7'h00, updateAddr}, 8'h00);
    clr_sw();
    bus.wr_byte(8'h34, ack);
    chk("low ack", {7'h00, ack}, 8'h01);
    chk("low update", {7'h00, updateAddr}, 8'h01);
    chk("low buffer", rxBufData, 8'h34);
    set_addr(8'hF2);
    clr_sw();
    bus.start();
    bus.wr_byte(8'hF3, ack);
    chk("restart ack", {7'h00, ack}, 8'h01);
    chk("no update", {7'h00, updateAddr}, 8'h00);
    chk("read dir", {7'h00, readNotWrite}, 8'h01);
    for (int i = 0; i < 9; i++) begin
      bus.rd_byte(i < 8, d);
      chk("sent byte", d, (i < 8) ? 8'(8'hC0 + i) : IDLE_TX_BYTE);
    end
    bus.stop();
  endtask

  // whole run is about 37 us of bus traffic
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("reset buffer", rxBufData, BUF_RESET);
    chk("reset address", slaveAddr, ADDR_RESET);
    t_modes();
    t_overflow();
    t_ten();
    give_verdict();
  end
endmodule
